// [hdl/stp_char.sv]
// character framer: one transmitter and one receiver
`timescale 1ns/1ps
`default_nettype none
module stp_char
  import stp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [17:0] i_div,
  input wire logic i_len8,
  input wire logic [1:0] i_par,
  input wire logic i_stop2,
  input wire logic i_tx_go,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_busy,
  output logic o_txd,
  input wire logic i_rx_en,
  input wire logic i_rxd,
  output logic o_rx_busy,
  output logic o_rx_vld,
  output logic [7:0] o_rx_data,
  output logic o_rx_err
);
  logic [17:0] tcnt_reg;
  logic [3:0] tbit_reg;
  logic [11:0] tsh_reg;
  logic [3:0] tlen;
  logic dpar;
  logic [17:0] rcnt_reg;
  logic [3:0] rbit_reg;
  logic [9:0] rsh_reg;
  logic [3:0] rlen;
  logic rpar;
  assign dpar = (i_len8 ? ^i_tx_data : ^i_tx_data[6:0]) ^ (i_par == 2'b10);
  // bits after start: data, parity, stops
  assign tlen = (i_len8 ? 4'h8 : 4'h7) + ((i_par != 2'b00) ? 4'h1 : 4'h0)
    + (i_stop2 ? 4'h2 : 4'h1);
  assign rlen = (i_len8 ? 4'h8 : 4'h7) + ((i_par != 2'b00) ? 4'h1 : 4'h0);

  // transmit shift: start low, lsb first, parity, high stops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tcnt_reg <= 18'h0;
      tbit_reg <= 4'h0;
      tsh_reg <= 12'hfff;
      o_tx_busy <= 1'b0;
      o_txd <= 1'b1;
    end else if (!o_tx_busy) begin
      o_txd <= 1'b1;
      if (i_tx_go) begin
        o_tx_busy <= 1'b1;
        o_txd <= 1'b0;
        tcnt_reg <= i_div - 18'h1;
        tbit_reg <= tlen;
        if (i_len8) begin
          tsh_reg <= (i_par != 2'b00) ? {2'b11, dpar, i_tx_data}
                                      : {3'b111, i_tx_data};
        end else begin
          tsh_reg <= (i_par != 2'b00) ? {3'b111, dpar, i_tx_data[6:0]}
                                      : {4'hf, i_tx_data[6:0]};
        end
      end
    end else if (tcnt_reg != 18'h0) begin
      tcnt_reg <= tcnt_reg - 18'h1;
    end else if (tbit_reg == 4'h0) begin
      o_tx_busy <= 1'b0;
      o_txd <= 1'b1;
    end else begin
      o_txd <= tsh_reg[0];
      tsh_reg <= {1'b1, tsh_reg[11:1]};
      tbit_reg <= tbit_reg - 4'h1;
      tcnt_reg <= i_div - 18'h1;
    end
  end

  // receive: sample mid bit, check parity and first stop
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rcnt_reg <= 18'h0;
      rbit_reg <= 4'h0;
      rsh_reg <= 10'h0;
      o_rx_busy <= 1'b0;
      o_rx_vld <= 1'b0;
      o_rx_data <= 8'h0;
      o_rx_err <= 1'b0;
    end else begin
      o_rx_vld <= 1'b0;
      if (!o_rx_busy) begin
        if (i_rx_en && !i_rxd) begin
          o_rx_busy <= 1'b1;
          rcnt_reg <= {1'b0, i_div[17:1]};
          rbit_reg <= 4'h0;
        end
      end else if (rcnt_reg != 18'h0) begin
        rcnt_reg <= rcnt_reg - 18'h1;
      end else if (rbit_reg == 4'h0 && i_rxd) begin
        o_rx_busy <= 1'b0; // false start, glitch only
      end else if (rbit_reg == rlen + 4'h1) begin
        o_rx_busy <= 1'b0;
        o_rx_vld <= 1'b1;
        // a parity bit lands on top, pushing the data one place down
        o_rx_data <= i_len8
          ? ((i_par != 2'b00) ? rsh_reg[8:1] : rsh_reg[9:2])
          : ((i_par != 2'b00) ? {1'b0, rsh_reg[8:2]} : {1'b0, rsh_reg[9:3]});
        o_rx_err <= !i_rxd || (rpar != 1'b0);
      end else begin
        if (rbit_reg != 4'h0) begin
          rsh_reg <= {i_rxd, rsh_reg[9:1]};
        end
        rbit_reg <= rbit_reg + 4'h1;
        rcnt_reg <= i_div - 18'h1;
      end
    end
  end
  // parity over data and parity bit; odd expects a set total
  always_comb begin
    rpar = 1'b0;
    if (i_par != 2'b00) begin
      rpar = (^rsh_reg[9:1]) ^ (i_par == 2'b10);
      if (!i_len8) begin
        rpar = (^rsh_reg[9:2]) ^ (i_par == 2'b10);
      end
    end
  end
endmodule : stp_char
`default_nettype wire

// [hdl/stp_top.sv]
// serial terminal port: wishbone registers, flow control, packetiser
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module stp_top
  import stp_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC,
  parameter int unsigned LED_CYCLES = LED_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic I_RXD,
  input wire logic I_RTS,
  input wire logic I_PEER_CTS,
  input wire logic I_DSR,
  input wire logic I_BUF_FULL,
  output logic O_TXD,
  output logic O_TX_EN,
  output logic O_CTS,
  output logic O_LINK_LED,
  output logic O_PKT_VLD,
  output logic [7:0] O_PKT_DATA,
  output logic O_PKT_END
);
  logic [6:0] ctrl_reg;
  logic [7:0] frame_reg;
  logic [15:0] mtu_reg;
  logic [15:0] gap_reg;
  logic [15:0] dly_reg;
  logic [15:0] hld_reg;
  logic [7:0] txd_reg;
  logic txfull_reg;
  logic [7:0] rxd_reg;
  logic rxfull_reg;
  logic rxerr_reg;
  logic [2:0] s_rxd_reg, s_rts_reg, s_cts_reg, s_dsr_reg;
  logic rxd_f_reg, rts_f_reg, cts_f_reg, dsr_f_reg;
  logic enabled, asleep;
  logic [1:0] ptype, flow;
  logic [17:0] div;
  logic tx_go, tx_busy, txd, rx_en, rx_busy, rx_vld, rx_err;
  logic [7:0] rx_data;
  logic wr, rd;
  logic [31:0] ms_cnt_reg;
  logic ms_tick;
  logic ms_arm;
  logic [15:0] ms_left_reg;
  logic cts_reg;
  logic key_lead_done;
  logic [1:0] key_st_reg;
  logic [15:0] pkt_cnt_reg;
  logic [31:0] gap_cnt_reg;
  logic [31:0] gap_lim;
  logic pkt_open_reg;
  logic [31:0] led_cnt_reg;

  assign enabled = ctrl_reg[CTRL_MODE];
  assign ptype = ctrl_reg[CTRL_PTYPE +: 2];
  assign flow = ctrl_reg[CTRL_FLOW +: 2];
  assign asleep = ctrl_reg[CTRL_SLEEP];
  assign div = stp_div(frame_reg[FRM_BAUD +: 4]);
  assign wr = I_WB_CYC && I_WB_STB && I_WB_WE && !O_WB_ACK;
  assign rd = I_WB_CYC && I_WB_STB && !I_WB_WE && !O_WB_ACK;

  // wishbone writes, single-cycle ack; low byte lanes carry fields
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_reg <= 7'h00;
      frame_reg <= {1'b0, 2'b00, 1'b1, BAUD_RST};
      mtu_reg <= MTU_RST;
      gap_reg <= GAP_RST;
      dly_reg <= CTS_MS_RST;
      hld_reg <= CTS_MS_RST;
    end else if (wr && I_WB_SEL[0]) begin
      unique case (I_WB_ADR)
        ADR_CTRL: ctrl_reg <= I_WB_DAT[6:0];
        ADR_FRAME: frame_reg <= I_WB_DAT[7:0];
        ADR_MTU: mtu_reg[7:0] <= I_WB_DAT[7:0];
        ADR_GAP: gap_reg[7:0] <= I_WB_DAT[7:0];
        ADR_CTSDLY: dly_reg[7:0] <= I_WB_DAT[7:0];
        ADR_CTSHLD: hld_reg[7:0] <= I_WB_DAT[7:0];
        default: ;
      endcase
      if (I_WB_SEL[1]) begin
        unique case (I_WB_ADR)
          ADR_MTU: mtu_reg[15:8] <= I_WB_DAT[15:8];
          ADR_GAP: gap_reg[15:8] <= I_WB_DAT[15:8];
          ADR_CTSDLY: dly_reg[15:8] <= I_WB_DAT[15:8];
          ADR_CTSHLD: hld_reg[15:8] <= I_WB_DAT[15:8];
          default: ;
        endcase
      end
    end
  end

  // ack and read mux; unmapped reads give zero
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0;
    end else begin
      O_WB_ACK <= I_WB_CYC && I_WB_STB && !O_WB_ACK;
      O_WB_DAT <= 32'h0;
      if (rd) begin
        unique case (I_WB_ADR)
          ADR_CTRL: O_WB_DAT <= {25'h0, ctrl_reg};
          ADR_FRAME: O_WB_DAT <= {24'h0, frame_reg};
          ADR_MTU: O_WB_DAT <= {16'h0, mtu_reg};
          ADR_GAP: O_WB_DAT <= {16'h0, gap_reg};
          ADR_CTSDLY: O_WB_DAT <= {16'h0, dly_reg};
          ADR_CTSHLD: O_WB_DAT <= {16'h0, hld_reg};
          ADR_RXDATA: O_WB_DAT <= {24'h0, rxd_reg};
          ADR_STATUS: O_WB_DAT <= {27'h0, cts_reg, rxerr_reg, rxfull_reg,
                                   tx_busy, txfull_reg};
          default: O_WB_DAT <= 32'h0;
        endcase
      end
    end
  end

  // tx holding byte; refused writes while full are dropped
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      txd_reg <= 8'h0;
      txfull_reg <= 1'b0;
    end else if (tx_go) begin
      txfull_reg <= 1'b0;
    end else if (wr && I_WB_SEL[0] && I_WB_ADR == ADR_TXDATA
                 && !txfull_reg && enabled) begin
      txd_reg <= I_WB_DAT[7:0];
      txfull_reg <= 1'b1;
    end
  end

  // rx holding byte; a new char wins over the read that empties it
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rxd_reg <= 8'h0;
      rxfull_reg <= 1'b0;
      rxerr_reg <= 1'b0;
    end else if (rx_vld) begin
      rxd_reg <= rx_data;
      rxfull_reg <= 1'b1;
      rxerr_reg <= rx_err;
    end else if (rd && I_WB_ADR == ADR_RXDATA) begin
      rxfull_reg <= 1'b0;
      rxerr_reg <= 1'b0;
    end
  end

  // pin synchronisers: three stages, change taken when last two agree
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      s_rxd_reg <= 3'b111;
      s_rts_reg <= 3'b000;
      s_cts_reg <= 3'b000;
      s_dsr_reg <= 3'b000;
      rxd_f_reg <= 1'b1;
      rts_f_reg <= 1'b0;
      cts_f_reg <= 1'b0;
      dsr_f_reg <= 1'b0;
    end else begin
      s_rxd_reg <= {s_rxd_reg[1:0], I_RXD};
      s_rts_reg <= {s_rts_reg[1:0], I_RTS};
      s_cts_reg <= {s_cts_reg[1:0], I_PEER_CTS};
      s_dsr_reg <= {s_dsr_reg[1:0], I_DSR};
      if (s_rxd_reg[1] == s_rxd_reg[2]) rxd_f_reg <= s_rxd_reg[2];
      if (s_rts_reg[1] == s_rts_reg[2]) rts_f_reg <= s_rts_reg[2];
      if (s_cts_reg[1] == s_cts_reg[2]) cts_f_reg <= s_cts_reg[2];
      if (s_dsr_reg[1] == s_dsr_reg[2]) dsr_f_reg <= s_dsr_reg[2];
    end
  end

  // millisecond tick shared by delay, lead and hold timers
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ms_cnt_reg <= 32'h0;
    end else if (ms_arm || ms_cnt_reg >= MS_CYCLES - 1) begin
      ms_cnt_reg <= 32'h0;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h1;
    end
  end
  assign ms_tick = (ms_cnt_reg >= MS_CYCLES - 1);
  // restart the tick while a timer is armed, so a delay is never short
  assign ms_arm = !enabled || asleep
    || (flow == STP_FC_RTS && (I_BUF_FULL || rts_f_reg == cts_reg))
    || (flow == STP_FC_KEY && (key_st_reg == 2'b00 || key_st_reg == 2'b10));

  // keying: 0 idle, 1 lead, 2 sending, 3 hold
  assign key_lead_done = (key_st_reg == 2'b10);
  // half duplex blocks tx while a char comes in, and rx while sending
  assign tx_go = txfull_reg && !tx_busy && enabled
    && (flow != STP_FC_KEY || key_lead_done)
    && !(ptype == STP_PT_485H && rx_busy);
  assign rx_en = enabled && !(ptype == STP_PT_485H
    && (tx_busy || txfull_reg));

  // clear-to-send per flow mode; timers count whole milliseconds
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cts_reg <= 1'b0;
      key_st_reg <= 2'b00;
      ms_left_reg <= 16'h0;
    end else if (!enabled || asleep) begin
      cts_reg <= 1'b0;
      key_st_reg <= 2'b00;
      ms_left_reg <= 16'h0;
    end else begin
      unique case (flow)
        STP_FC_RTS: begin
          key_st_reg <= 2'b00;
          if (I_BUF_FULL) begin
            cts_reg <= 1'b0;
            ms_left_reg <= dly_reg;
          end else if (rts_f_reg == cts_reg) begin
            ms_left_reg <= dly_reg;
          end else if (ms_left_reg == 16'h0) begin
            cts_reg <= rts_f_reg;
            ms_left_reg <= dly_reg;
          end else if (ms_tick) begin
            ms_left_reg <= ms_left_reg - 16'h1;
          end
        end
        STP_FC_KEY: begin
          unique case (key_st_reg)
            2'b00: begin
              cts_reg <= txfull_reg;
              ms_left_reg <= dly_reg;
              if (txfull_reg) key_st_reg <= 2'b01;
            end
            2'b01: begin
              if (ms_left_reg == 16'h0) key_st_reg <= 2'b10;
              else if (ms_tick) ms_left_reg <= ms_left_reg - 16'h1;
            end
            2'b10: begin
              ms_left_reg <= hld_reg;
              if (!txfull_reg && !tx_busy) key_st_reg <= 2'b11;
            end
            2'b11: begin
              if (txfull_reg) begin
                key_st_reg <= 2'b10;
              end else if (ms_left_reg == 16'h0) begin
                cts_reg <= 1'b0;
                key_st_reg <= 2'b00;
              end else if (ms_tick) begin
                ms_left_reg <= ms_left_reg - 16'h1;
              end
            end
          endcase
        end
        default: begin
          cts_reg <= 1'b1;
          key_st_reg <= 2'b00;
        end
      endcase
    end
  end

  // gap limit in cycles: tenths of a char, char taken as 10 bits
  assign gap_lim = 32'(gap_reg) * 32'(div);

  // packetiser: close on mtu count or idle gap after last byte
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pkt_cnt_reg <= 16'h0;
      gap_cnt_reg <= 32'h0;
      pkt_open_reg <= 1'b0;
      O_PKT_VLD <= 1'b0;
      O_PKT_DATA <= 8'h0;
      O_PKT_END <= 1'b0;
    end else begin
      O_PKT_VLD <= 1'b0;
      O_PKT_END <= 1'b0;
      if (rx_vld && enabled) begin
        O_PKT_VLD <= 1'b1;
        O_PKT_DATA <= rx_data;
        gap_cnt_reg <= 32'h0;
        if (pkt_cnt_reg + 16'h1 >= mtu_reg) begin
          O_PKT_END <= 1'b1;
          pkt_cnt_reg <= 16'h0;
          pkt_open_reg <= 1'b0;
        end else begin
          pkt_cnt_reg <= pkt_cnt_reg + 16'h1;
          pkt_open_reg <= 1'b1;
        end
      end else if (pkt_open_reg && !rx_busy) begin
        gap_cnt_reg <= gap_cnt_reg + 32'h1;
        if (gap_cnt_reg >= gap_lim) begin
          O_PKT_END <= 1'b1;
          pkt_cnt_reg <= 16'h0;
          pkt_open_reg <= 1'b0;
        end
      end
    end
  end

  // link led: auto on rs-232 watches peer lines and recent data
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      led_cnt_reg <= 32'h0;
      O_LINK_LED <= 1'b0;
    end else begin
      if (rx_vld) led_cnt_reg <= LED_CYCLES;
      else if (led_cnt_reg != 32'h0) led_cnt_reg <= led_cnt_reg - 32'h1;
      O_LINK_LED <= ctrl_reg[CTRL_LEDON] || ptype != STP_PT_232
        || cts_f_reg || dsr_f_reg || led_cnt_reg != 32'h0;
    end
  end

  // registered pin outputs
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_TXD <= 1'b1;
      O_CTS <= 1'b0;
      O_TX_EN <= 1'b0;
    end else begin
      O_TXD <= txd;
      O_CTS <= cts_reg;
      O_TX_EN <= tx_busy;
    end
  end

  stp_char u_char (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_div(div),
    .i_len8(frame_reg[FRM_LEN8]),
    .i_par(frame_reg[FRM_PAR +: 2]),
    .i_stop2(frame_reg[FRM_STOP2]),
    .i_tx_go(tx_go),
    .i_tx_data(txd_reg),
    .o_tx_busy(tx_busy),
    .o_txd(txd),
    .i_rx_en(rx_en),
    .i_rxd(rxd_f_reg),
    .o_rx_busy(rx_busy),
    .o_rx_vld(rx_vld),
    .o_rx_data(rx_data),
    .o_rx_err(rx_err)
  );

  AST_NONE_CTS: assert property (@(posedge I_CLK) disable iff (I_RST)
    (enabled && !asleep && flow == STP_FC_NONE) |=> cts_reg)
    else $error("cts not held in no-flow mode");
  AST_SLEEP_CTS: assert property (@(posedge I_CLK) disable iff (I_RST)
    asleep |=> !cts_reg)
    else $error("cts on while asleep");
  AST_FULL_CTS: assert property (@(posedge I_CLK) disable iff (I_RST)
    (enabled && flow == STP_FC_RTS && I_BUF_FULL) |=> !cts_reg)
    else $error("cts on with buffer full");
  AST_RTS_FOLLOW: assert property (@(posedge I_CLK) disable iff (I_RST)
    (enabled && !asleep && flow == STP_FC_RTS && !I_BUF_FULL
     && ms_left_reg == 16'h0 && rts_f_reg != cts_reg)
    |=> cts_reg == $past(rts_f_reg))
    else $error("cts does not follow rts");
  AST_KEY_TX: assert property (@(posedge I_CLK) disable iff (I_RST)
    (flow == STP_FC_KEY && tx_go) |-> cts_reg)
    else $error("keyed send without cts");
  AST_HALF_DUP: assert property (@(posedge I_CLK) disable iff (I_RST)
    (ptype == STP_PT_485H && tx_busy) |-> !$rose(rx_busy))
    else $error("half duplex rx started while sending");
  AST_MTU_END: assert property (@(posedge I_CLK) disable iff (I_RST)
    (O_PKT_VLD && !pkt_open_reg) |-> O_PKT_END)
    else $error("mtu close missing end");
  AST_START_LOW: assert property (@(posedge I_CLK) disable iff (I_RST)
    $rose(tx_busy) |=> !O_TXD)
    else $error("start bit not low");
endmodule : stp_top
`default_nettype wire

// [inc/stp_pkg.sv]
// package: constants and types for the serial terminal port
package stp_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_FRAME = 8'h04;
  localparam logic [7:0] ADR_MTU = 8'h08;
  localparam logic [7:0] ADR_GAP = 8'h0c;
  localparam logic [7:0] ADR_CTSDLY = 8'h10;
  localparam logic [7:0] ADR_CTSHLD = 8'h14;
  localparam logic [7:0] ADR_TXDATA = 8'h18;
  localparam logic [7:0] ADR_RXDATA = 8'h1c;
  localparam logic [7:0] ADR_STATUS = 8'h20;
  // ctrl fields
  localparam int CTRL_MODE = 0;
  localparam int CTRL_PTYPE = 1;
  localparam int CTRL_FLOW = 3;
  localparam int CTRL_SLEEP = 5;
  localparam int CTRL_LEDON = 6;
  // frame fields
  localparam int FRM_BAUD = 0;
  localparam int FRM_LEN8 = 4;
  localparam int FRM_PAR = 5;
  localparam int FRM_STOP2 = 7;
  localparam logic [3:0] BAUD_RST = 4'h5;
  localparam logic [15:0] MTU_RST = 16'h0200;
  localparam logic [15:0] GAP_RST = 16'h0023;
  localparam logic [15:0] CTS_MS_RST = 16'h0000;
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  localparam int unsigned LED_S = 10;
  localparam int unsigned LED_CYC = LED_S * CLK_HZ;
  typedef enum logic [1:0] {
    STP_PT_232 = 2'b00, STP_PT_422 = 2'b01,
    STP_PT_485H = 2'b10, STP_PT_485F = 2'b11
  } stp_ptype_t;
  typedef enum logic [1:0] {
    STP_FC_NONE = 2'b00, STP_FC_RTS = 2'b01, STP_FC_KEY = 2'b10
  } stp_flow_t;
  typedef enum logic [1:0] {
    STP_PAR_NONE = 2'b00, STP_PAR_EVEN = 2'b01, STP_PAR_ODD = 2'b10
  } stp_par_t;
  // bit clocks per baud code, 50 MHz / rate
  function automatic logic [17:0] stp_div(input logic [3:0] code);
    case (code)
      4'h0: stp_div = 18'd166667;
      4'h1: stp_div = 18'd83333;
      4'h2: stp_div = 18'd41667;
      4'h3: stp_div = 18'd20833;
      4'h4: stp_div = 18'd10417;
      4'h6: stp_div = 18'd2604;
      4'h7: stp_div = 18'd1302;
      4'h8: stp_div = 18'd868;
      4'h9: stp_div = 18'd434;
      default: stp_div = 18'd5208;
    endcase
  endfunction : stp_div
endpackage : stp_pkg

// [testbench/stp_dte_model.sv]
// far-side terminal model: drives the rx line and rts, samples tx
`timescale 1ns/1ps
`default_nettype none
module stp_dte_model #(
  parameter int BIT = 434
) (
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd = 1'b1,
  output logic o_rts = 1'b0
);
  // request line, changed only through this task
  task automatic set_rts(input logic v);
    o_rts <= v;
  endtask : set_rts
  // 8e1 frame, start low, lsb first, bad flips parity
  task automatic send_char(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    f = {1'b1, ^d ^ bad, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      o_rxd <= f[i];
      repeat (BIT) @(posedge i_clk);
    end
  endtask : send_char
  // mid-cell sampling keeps a few cycles of skew harmless
  task automatic get_char(output logic [11:0] f);
    int n;
    f = '0;
    n = 0;
    while (i_txd !== 1'b0 && n < 9000) begin
      @(posedge i_clk);
      n++;
    end
    repeat (BIT / 2) @(posedge i_clk);
    for (int i = 0; i < 12; i++) begin
      f[i] = i_txd;
      repeat (BIT) @(posedge i_clk);
    end
  endtask : get_char
endmodule : stp_dte_model
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the serial terminal port
`timescale 1ns/1ps
`default_nettype none
module tb;
  import stp_pkg::*;
  localparam int BIT = 434;
  localparam int MS = 10;
  localparam int LEDC = 100;
  logic I_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic I_WB_CYC = 1'b0, I_WB_STB = 1'b0, I_WB_WE = 1'b0;
  logic [7:0] I_WB_ADR = 8'h00;
  logic [3:0] I_WB_SEL = 4'h0;
  logic [31:0] I_WB_DAT = 32'h0;
  logic I_RXD, I_RTS, I_PEER_CTS = 1'b0, I_DSR = 1'b0, I_BUF_FULL = 1'b0;
  logic [31:0] O_WB_DAT;
  logic O_WB_ACK, O_TXD, O_TX_EN, O_CTS, O_LINK_LED, O_PKT_VLD, O_PKT_END;
  logic [7:0] O_PKT_DATA;
  int miscompares = 0;
  int n_compared = 0;
  // rows: frame, tx byte, expected 12 line bits, bits in frame
  logic [31:0] rows [4] = '{32'h19a5f4aa, 32'hb9a5d4ac, 32'hc935f6ab,
    32'h39a7f4eb};
  // reset rows: address, expected read value
  logic [39:0] rst_rows [6] = '{{ADR_CTRL, 32'h0}, {ADR_FRAME, 32'h15},
    {ADR_MTU, 32'h200}, {ADR_GAP, 32'h23}, {ADR_CTSHLD, 32'h0},
    {8'h40, 32'h0}};
  always #10 I_CLK = ~I_CLK;
  // ms counts shortened so delays stay a few dozen cycles
  stp_top #(.MS_CYCLES(MS), .LED_CYCLES(LEDC)) dut_u (.I_CLK, .I_RST,
    .I_WB_CYC, .I_WB_STB, .I_WB_WE, .I_WB_ADR, .I_WB_SEL, .I_WB_DAT,
    .O_WB_DAT, .O_WB_ACK, .I_RXD, .I_RTS, .I_PEER_CTS, .I_DSR,
    .I_BUF_FULL, .O_TXD, .O_TX_EN, .O_CTS, .O_LINK_LED, .O_PKT_VLD,
    .O_PKT_DATA, .O_PKT_END);
  stp_dte_model #(.BIT(BIT)) dte_u (.i_clk(I_CLK), .i_txd(O_TXD),
    .o_rxd(I_RXD), .o_rts(I_RTS));
  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic cmp(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic cmp_rng(input string nm, input int lo, input int hi,
    input int g);
    n_compared++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", nm, lo, hi, g);
    end
  endtask : cmp_rng
  // bounded wait; a hang ends the run as a mismatch
  task automatic wait_sig(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 40000) begin
      @(posedge I_CLK);
      n++;
    end
    if (n >= 40000) begin
      miscompares++;
      print_verdict();
    end
  endtask : wait_sig
  // classic single cycle; held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    I_WB_CYC <= 1'b1;
    I_WB_STB <= 1'b1;
    I_WB_WE <= we;
    I_WB_ADR <= a;
    I_WB_DAT <= d;
    I_WB_SEL <= 4'h3;
    @(posedge I_CLK);
    wait_sig(O_WB_ACK, 1'b1, n);
    q = O_WB_DAT;
    I_WB_CYC <= 1'b0;
    I_WB_STB <= 1'b0;
    @(posedge I_CLK);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  initial begin
    logic [31:0] q;
    logic [31:0] r;
    logic [11:0] f;
    int n;
    int m;
    repeat (4) @(posedge I_CLK);
    I_RST <= 1'b0;
    @(posedge I_CLK);
    wr(ADR_CTRL, 32'h01);
    // each row: configure, send one byte, read the line back
    foreach (rows[i]) begin
      r = rows[i];
      wr(ADR_FRAME, {24'h0, r[31:24]});
      wr(ADR_TXDATA, {24'h0, r[23:16]});
      fork
        dte_u.get_char(f);
        begin
          wait_sig(O_TX_EN, 1'b1, n);
          wait_sig(O_TX_EN, 1'b0, m);
        end
      join
      cmp("tx frame", {20'h0, r[15:4]}, {20'h0, f});
      cmp("tx bits", {28'h0, r[3:0]}, (m + BIT / 2) / BIT);
    end
    // request-following flow control
    wr(ADR_CTRL, 32'h09);
    dte_u.set_rts(1'b1);
    repeat (12) @(posedge I_CLK);
    cmp("cts rts", 32'h1, {31'h0, O_CTS});
    I_BUF_FULL <= 1'b1;
    repeat (4) @(posedge I_CLK);
    cmp("cts full", 32'h0, {31'h0, O_CTS});
    I_BUF_FULL <= 1'b0;
    wr(ADR_CTSDLY, 32'h3);
    repeat (12) @(posedge I_CLK);
    dte_u.set_rts(1'b0);
    @(posedge I_CLK);
    wait_sig(O_CTS, 1'b0, n);
    cmp_rng("cts delay", 3 * MS - 2, 3 * MS + 8, n);
    // keying: lead before data, hold after it
    wr(ADR_CTSHLD, 32'h2);
    wr(ADR_CTRL, 32'h11);
    wr(ADR_TXDATA, 32'h5a);
    wait_sig(O_CTS, 1'b1, n);
    wait_sig(O_TX_EN, 1'b1, n);
    cmp_rng("key lead", 3 * MS - 2, 3 * MS + 8, n);
    wait_sig(O_TX_EN, 1'b0, n);
    wait_sig(O_CTS, 1'b0, n);
    cmp_rng("key hold", 2 * MS - 2, 2 * MS + 8, n);
    // no flow control: awake, asleep, disabled
    wr(ADR_CTRL, 32'h01);
    repeat (4) @(posedge I_CLK);
    cmp("cts none", 32'h1, {31'h0, O_CTS});
    wr(ADR_CTRL, 32'h21);
    repeat (4) @(posedge I_CLK);
    cmp("cts sleep", 32'h0, {31'h0, O_CTS});
    wr(ADR_CTRL, 32'h00);
    repeat (4) @(posedge I_CLK);
    cmp("cts off", 32'h0, {31'h0, O_CTS});
    wr(ADR_CTRL, 32'h01);
    // receive: gap closes the packet, then a one-byte limit
    fork
      dte_u.send_char(8'h3c, 1'b0);
      begin
        wait_sig(O_PKT_VLD, 1'b1, n);
        r = {24'h0, O_PKT_DATA};
        q = {31'h0, O_PKT_END};
      end
    join
    cmp("rx data", 32'h3c, r);
    cmp("rx end", 32'h0, q);
    wait_sig(O_PKT_END, 1'b1, n);
    cmp_rng("rx gap", 34 * BIT, 37 * BIT, n);
    wr(ADR_MTU, 32'h1);
    fork
      dte_u.send_char(8'hc3, 1'b0);
      begin
        wait_sig(O_PKT_VLD, 1'b1, n);
        r = {24'h0, O_PKT_DATA};
        q = {31'h0, O_PKT_END};
      end
    join
    cmp("rx data", 32'hc3, r);
    cmp("rx end", 32'h1, q);
    dte_u.send_char(8'h55, 1'b1);
    wb(1'b0, ADR_STATUS, 32'h0, q);
    cmp("rx err", 32'h1, {31'h0, q[3]});
    // link indicator follows dsr, lapses once data is old
    I_DSR <= 1'b1;
    repeat (8) @(posedge I_CLK);
    cmp("led", 32'h1, {31'h0, O_LINK_LED});
    I_DSR <= 1'b0;
    repeat (LEDC + 40) @(posedge I_CLK);
    cmp("led", 32'h0, {31'h0, O_LINK_LED});
    // half duplex: a char arriving while sending is not taken
    wr(ADR_CTRL, 32'h05);
    wr(ADR_TXDATA, 32'h33);
    m = 0;
    fork
      dte_u.send_char(8'h11, 1'b0);
      repeat (12 * BIT) begin
        @(posedge I_CLK);
        if (O_PKT_VLD === 1'b1) m++;
      end
    join
    cmp("half duplex rx", 32'h0, m);
    // second reset in mid-run, then reset values
    I_RST <= 1'b1;
    repeat (2) @(posedge I_CLK);
    cmp("txd rst", 32'h1, {31'h0, O_TXD});
    cmp("cts rst", 32'h0, {31'h0, O_CTS});
    I_RST <= 1'b0;
    @(posedge I_CLK);
    foreach (rst_rows[i]) begin
      wb(1'b0, rst_rows[i][39:32], 32'h0, q);
      cmp("reset value", rst_rows[i][31:0], q);
    end
    print_verdict();
  end
endmodule : tb
`default_nettype wire
